// ==== design/ang_pkg.sv ====
package ang_pkg;
  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int BREAK_LINK_MS = 1500;
  localparam int BLINK_MS = 50;
  localparam int LINK_LOSS_MS = 100;
  localparam int BREAK_CYC = BREAK_LINK_MS * CYC_PER_MS;
  localparam int BLINK_CYC = BLINK_MS * CYC_PER_MS;
  localparam int LOSS_CYC = LINK_LOSS_MS * CYC_PER_MS;
  localparam int TMR_W = 26;
  localparam logic [2:0] NLP_GOOD = 3'h6;
  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_ABILITY_ADV = 5'h04;
  localparam logic [4:0] REG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] REG_NEG_EXPANSION = 5'h06;
  localparam logic [4:0] REG_STATUS_SUMMARY = 5'h10;
  localparam logic [4:0] REG_IND_DIRECT = 5'h18;
  localparam logic [4:0] REG_XCVR_CONTROL = 5'h19;
  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int BC_RESET = 15;
  localparam int BC_SPEED = 13;
  localparam int BC_NEGOTIATE_STRAP_ENABLE = 12;
  localparam int BC_RESTART = 9;
  localparam int BC_DUPLEX = 8;
  localparam int ADV_RF = 13;
  localparam int ADV_LSB = 5;
  localparam int XC_MDIX_EN = 15;
  localparam int XC_FORCE = 14;
  localparam int XC_LED_LSB = 5;
  // ********************************************************
  // Fixed and reset values
  // ********************************************************
  localparam logic [15:0] STATUS_FIXED = 16'h7849;
  localparam logic [4:0] SELECTOR = 5'h01;
  localparam logic [15:0] PD_WORD_100 = 16'h0081;
  localparam logic [15:0] PD_WORD_10 = 16'h0021;
  localparam logic LOCAL_NP_ABLE = 1'b0;
  localparam logic [3:0] ADV_10_BOTH = 4'h3;
  localparam logic [3:0] ADV_100_BOTH = 4'hC;
  localparam logic [3:0] ADV_HALF_BOTH = 4'h5;
  localparam logic [3:0] ADV_ALL = 4'hF;
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  typedef enum logic [3:0] {
    ST_FORCED = 4'h1,
    ST_BREAK = 4'h2,
    ST_ABILITY = 4'h4,
    ST_COMPLETE = 4'h8
  } ang_state_t;
endpackage

// ==== design/ang_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ang_timer #(
  parameter int W = 26
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic start_in,
  input wire logic [W-1:0] limit_in,
  // Status
  output logic busy_out,
  output logic done_out
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [W-1:0] cnt;
  } ang_tmr_t;
  ang_tmr_t s, next_s;
  // A restart reloads the count, so a pending expiry is cancelled.
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start_in) begin
      next_s.busy = 1'b1;
      next_s.cnt = limit_in - 1'b1;
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign busy_out = s.busy;
  assign done_out = s.done;
endmodule
`default_nettype wire

// ==== design/ang_link_ctrl.sv ====
// Summary of operation
// - While negotiating, send the advertisement register contents in link pulse bursts.
// - Resolve 100 full, then 100 half, then 10 full, then 10 half.
// - Without negotiation, speed and duplex control bits pick the mode.
// - Status summary reports resolved speed once link is up.
// - Basic status shows fixed abilities, no T4, completion, fault, link, preamble.
// - Advertisement resets to the strap-selected abilities; cleared abilities are no longer offered.
// - Partner register holds received page, or fixed words after parallel detect.
// - Expansion register flags fault, partner/local next page, page received, partner able.
// - Single valid 10 or 100 link from non-negotiating partner selects that mode.
// - Parallel detect sets partner bit 5 or 7 and selector 00001.
// - After parallel detect, partner-able reads zero while complete reads one.
// - Parallel detect with both 10 and 100 links good sets fault flag.
// - Writing restart restarts negotiation any time after completion.
// - Losing link in negotiated mode resumes negotiation.
// - Renegotiation halts all pulses until break timer ends, then bursts resume.
// - Auto crossover enable loaded from its strap at reset, or register set, random seed toggling.
// - No auto crossover when forced; force bit swaps pairs always.
// - Indicator mode follows the two-bit configuration field, three modes.
// - 10 Mbps link after seven link pulses or one packet; drops on loss timer.
// - Each indicator polarity comes from its strap level sampled at reset.
// - Direct control register overrides indicators and never reads their live state.
// - Negotiation straps sampled at reset set the four advertised abilities.
`timescale 1ns/1ps
`default_nettype none
module ang_link_ctrl
  import ang_pkg::*;
#(
  parameter int BREAK_CYCLES = BREAK_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int LOSS_CYCLES = LOSS_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Straps
  input wire logic negotiate_strap_enable_in,
  input wire logic ability_strap_high_in,
  input wire logic ability_strap_low_in,
  input wire logic indicator_mode_select_in,
  input wire logic crossover_strap_enable_in,
  // Management register port
  input wire logic [4:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Receiver and negotiation link side
  input wire logic link100_in,
  input wire logic link_pulse_in,
  input wire logic packet10_valid_in,
  input wire logic [15:0] rx_page_in,
  input wire logic rx_page_valid_in,
  input wire logic tx_activity_in,
  input wire logic rx_activity_in,
  input wire logic collision_in,
  output logic flp_send_out,
  output logic [15:0] flp_word_out,
  output logic tx_halt_out,
  output logic crossover_out,
  output logic link_up_out,
  output logic speed100_out,
  output logic full_duplex_out,
  // Indicators
  output logic link_indicator_out,
  output logic speed_indicator_out,
  output logic activity_collision_indicator_out
);
  // ********************************************************
  // Reset release
  // ********************************************************
  logic rst_meta_n, rst_sync_n;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end
  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic loaded;
    ang_state_t st;
    logic speed_sel;
    logic duplex_sel;
    logic negotiate_strap_enable;
    logic [3:0] adv;
    logic adv_rf;
    logic [15:0] lpar;
    logic pdf;
    logic page_rx;
    logic lp_able;
    logic mdix_en;
    logic force_x;
    logic [1:0] indicator_mode_select;
    logic [5:0] indicator_direct_control;
    logic [2:0] pol;
    logic link10;
    logic [2:0] nlp_cnt;
    logic blink;
    logic [7:0] lfsr;
    logic res100;
    logic resfd;
    logic [2:0] ind;
    logic xover;
    logic flp_send;
    logic [15:0] flp_word;
    logic tx_halt;
    logic link_up;
    logic [15:0] rdata;
    logic rvalid;
  } ang_regs_t;
  ang_regs_t s, next_s;
  logic brk_done, loss_done, blk_done, blk_busy, brk_start, link_start;
  logic link_cur, act, restart_w, an_rise;
  logic [3:0] common;
  logic [2:0] on;
  logic [15:0] adv_word;
  function automatic logic [1:0] resolve(input logic [3:0] c);
    if (c[3]) begin
      resolve = 2'h3;
    end else if (c[2]) begin
      resolve = 2'h2;
    end else if (c[1]) begin
      resolve = 2'h1;
    end else begin
      resolve = 2'h0;
    end
  endfunction
  function automatic logic [3:0] strap_adv(input logic en, input logic hi, input logic lo);
    case ({en, hi, lo})
      3'h4: strap_adv = ADV_10_BOTH;
      3'h5: strap_adv = ADV_100_BOTH;
      3'h6: strap_adv = ADV_HALF_BOTH;
      default: strap_adv = ADV_ALL;
    endcase
  endfunction
  // ********************************************************
  // Timers
  // ********************************************************
  assign brk_start = (next_s.st == ST_BREAK) && (s.st != ST_BREAK);
  assign link_start = link_pulse_in | packet10_valid_in;
  ang_timer #(.W(TMR_W)) u_break (
    .clk_in(ref_clk_in), .rst_n_in(rst_sync_n), .start_in(brk_start),
    .limit_in(TMR_W'(BREAK_CYCLES)), .busy_out(), .done_out(brk_done)
  );
  ang_timer #(.W(TMR_W)) u_loss (
    .clk_in(ref_clk_in), .rst_n_in(rst_sync_n), .start_in(link_start),
    .limit_in(TMR_W'(LOSS_CYCLES)), .busy_out(), .done_out(loss_done)
  );
  ang_timer #(.W(TMR_W)) u_blink (
    .clk_in(ref_clk_in), .rst_n_in(rst_sync_n), .start_in(!blk_busy),
    .limit_in(TMR_W'(BLINK_CYCLES)), .busy_out(blk_busy), .done_out(blk_done)
  );
  // ********************************************************
  // Next state
  // ********************************************************
  assign link_cur = s.res100 ? link100_in : s.link10;
  assign act = tx_activity_in | rx_activity_in;
  assign common = s.adv & rx_page_in[8:5];
  assign adv_word = {2'h0, s.adv_rf, 4'h0, s.adv, SELECTOR};
  assign restart_w = reg_wr_in && (reg_addr_in == REG_BASIC_CONTROL) && reg_wdata_in[BC_RESTART];
  assign an_rise = reg_wr_in && (reg_addr_in == REG_BASIC_CONTROL) && reg_wdata_in[BC_NEGOTIATE_STRAP_ENABLE] && !s.negotiate_strap_enable;
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    on = 3'h0;
    if (!s.loaded) begin
      next_s.loaded = 1'b1;
      next_s.negotiate_strap_enable = negotiate_strap_enable_in;
      next_s.speed_sel = ability_strap_high_in;
      next_s.duplex_sel = ability_strap_low_in;
      next_s.adv = strap_adv(negotiate_strap_enable_in, ability_strap_high_in, ability_strap_low_in);
      next_s.adv_rf = 1'b0;
      next_s.lpar = 16'h0000;
      next_s.pdf = 1'b0;
      next_s.page_rx = 1'b0;
      next_s.lp_able = 1'b0;
      next_s.mdix_en = crossover_strap_enable_in;
      next_s.force_x = 1'b0;
      next_s.indicator_mode_select = {1'b0, indicator_mode_select_in};
      next_s.indicator_direct_control = 6'h00;
      next_s.pol = {negotiate_strap_enable_in, ability_strap_high_in, ability_strap_low_in};
      next_s.st = negotiate_strap_enable_in ? ST_ABILITY : ST_FORCED;
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          REG_BASIC_CONTROL: begin
            next_s.speed_sel = reg_wdata_in[BC_SPEED];
            next_s.duplex_sel = reg_wdata_in[BC_DUPLEX];
            next_s.negotiate_strap_enable = reg_wdata_in[BC_NEGOTIATE_STRAP_ENABLE];
            next_s.loaded = !reg_wdata_in[BC_RESET];
          end
          REG_ABILITY_ADV: begin
            next_s.adv = reg_wdata_in[ADV_LSB+3:ADV_LSB];
            next_s.adv_rf = reg_wdata_in[ADV_RF];
          end
          REG_IND_DIRECT: next_s.indicator_direct_control = reg_wdata_in[5:0];
          REG_XCVR_CONTROL: begin
            next_s.mdix_en = reg_wdata_in[XC_MDIX_EN];
            next_s.force_x = reg_wdata_in[XC_FORCE];
            next_s.indicator_mode_select = reg_wdata_in[XC_LED_LSB+1:XC_LED_LSB];
          end
          default: next_s.rvalid = 1'b0;
        endcase
      end
      if (reg_rd_in) begin
        next_s.rvalid = 1'b1;
        case (reg_addr_in)
          REG_BASIC_CONTROL: next_s.rdata = {2'h0, s.speed_sel, s.negotiate_strap_enable, 3'h0, s.duplex_sel, 8'h00};
          REG_BASIC_STATUS: next_s.rdata = STATUS_FIXED | {10'h000, s.st == ST_COMPLETE,
                                                           s.lpar[13], 1'b0, s.link_up, 2'h0};
          REG_ABILITY_ADV: next_s.rdata = adv_word;
          REG_PARTNER_ABILITY: next_s.rdata = s.lpar;
          REG_NEG_EXPANSION: begin
            next_s.rdata = {11'h000, s.pdf, s.lpar[15] & s.lp_able, LOCAL_NP_ABLE, s.page_rx, s.lp_able};
            next_s.pdf = 1'b0;
            next_s.page_rx = 1'b0;
          end
          REG_STATUS_SUMMARY: next_s.rdata = {11'h000, s.st == ST_COMPLETE, 1'b0, s.resfd,
                                              !s.res100, s.link_up};
          REG_IND_DIRECT: next_s.rdata = {10'h000, s.indicator_direct_control};
          REG_XCVR_CONTROL: next_s.rdata = {s.mdix_en, s.force_x, 7'h00, s.indicator_mode_select, 5'h00};
          default: next_s.rdata = 16'h0000;
        endcase
      end
      // 10 Mbps link qualification from link pulses, packets and the loss timer.
      if (loss_done) begin
        next_s.link10 = 1'b0;
        next_s.nlp_cnt = 3'h0;
      end else if (link_pulse_in && s.nlp_cnt != 3'h7) begin
        next_s.nlp_cnt = 3'(s.nlp_cnt + 3'h1);
      end
      if ((link_pulse_in && s.nlp_cnt == NLP_GOOD && !loss_done) || packet10_valid_in) begin
        next_s.link10 = 1'b1;
      end
      if (blk_done) begin
        next_s.blink = !s.blink;
        next_s.lfsr = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
      end
      case (s.st)
        ST_FORCED: begin
          next_s.res100 = s.speed_sel;
          next_s.resfd = s.duplex_sel;
          if (an_rise) begin
            next_s.st = ST_BREAK;
          end
        end
        ST_BREAK: begin
          if (brk_done) begin
            next_s.st = ST_ABILITY;
          end
        end
        ST_ABILITY: begin
          if (rx_page_valid_in) begin
            next_s.lpar = rx_page_in;
            next_s.page_rx = 1'b1;
            next_s.lp_able = 1'b1;
            if (common != 4'h0) begin
              {next_s.res100, next_s.resfd} = resolve(common);
              next_s.st = ST_COMPLETE;
            end
          end else if (link100_in ^ s.link10) begin
            next_s.lpar = link100_in ? PD_WORD_100 : PD_WORD_10;
            next_s.lp_able = 1'b0;
            next_s.res100 = link100_in;
            next_s.resfd = 1'b0;
            next_s.st = ST_COMPLETE;
          end else if (link100_in && s.link10) begin
            next_s.pdf = 1'b1;
          end
        end
        ST_COMPLETE: begin
          if (s.link_up && !link_cur) begin
            next_s.st = ST_BREAK;
          end
        end
        default: next_s.st = ST_FORCED;
      endcase
      if (!next_s.negotiate_strap_enable) begin
        next_s.st = ST_FORCED;
      end else if (restart_w && s.st != ST_FORCED) begin
        next_s.st = ST_BREAK;
      end
    end
    // Send and halt outputs register from the settled state; link, crossover and indicators from the current state.
    next_s.flp_send = next_s.st == ST_ABILITY;
    next_s.flp_word = adv_word;
    next_s.tx_halt = next_s.st == ST_BREAK;
    next_s.link_up = (s.st == ST_COMPLETE || s.st == ST_FORCED) && link_cur;
    if (s.force_x) begin
      next_s.xover = 1'b1;
    end else if (s.st == ST_FORCED || !s.mdix_en) begin
      next_s.xover = 1'b0;
    end else if (s.st == ST_ABILITY && blk_done && s.lfsr[0]) begin
      next_s.xover = !s.xover;
    end
    on[2] = s.link_up && !(!s.indicator_mode_select[0] && act && s.blink);
    on[1] = s.link_up && s.res100;
    if (s.indicator_mode_select[0]) begin
      on[0] = act;
    end else if (s.indicator_mode_select[1]) begin
      on[0] = s.link_up && s.resfd;
    end else begin
      on[0] = collision_in;
    end
    for (int i = 0; i < 3; i++) begin
      next_s.ind[i] = (s.indicator_direct_control[i+3] ? s.indicator_direct_control[i] : on[i]) ^ s.pol[i];
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
      s.st <= ST_FORCED;
      s.lfsr <= LFSR_SEED;
    end else begin
      s <= next_s;
    end
  end
  // ********************************************************
  // Outputs
  // ********************************************************
  assign reg_rdata_out = s.rdata;
  assign reg_rvalid_out = s.rvalid;
  assign flp_send_out = s.flp_send;
  assign flp_word_out = s.flp_word;
  assign tx_halt_out = s.tx_halt;
  assign crossover_out = s.xover;
  assign link_up_out = s.link_up;
  assign speed100_out = s.res100;
  assign full_duplex_out = s.resfd;
  assign link_indicator_out = s.ind[2];
  assign speed_indicator_out = s.ind[1];
  assign activity_collision_indicator_out = s.ind[0];
  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_sync_n);
  a_adv_sent: assert property (flp_send_out |-> flp_word_out[8:5] == $past(s.adv))
    else $error("advertised word differs from register");
  a_resolve_top: assert property (s.loaded && s.st == ST_ABILITY && rx_page_valid_in && s.adv[3]
      && rx_page_in[8] && !reg_wr_in |=> s.res100 && s.resfd && s.st == ST_COMPLETE)
    else $error("top common mode not chosen");
  a_pd_word: assert property (s.loaded && s.st == ST_ABILITY && !rx_page_valid_in && link100_in
      && !s.link10 && !reg_wr_in |=> s.lpar == PD_WORD_100 && !s.lp_able)
    else $error("parallel detect word wrong");
  a_pd_selector: assert property (s.st == ST_COMPLETE && !s.lp_able |-> s.lpar[4:0] == SELECTOR)
    else $error("selector missing after parallel detect");
  a_pd_fault: assert property (s.loaded && s.st == ST_ABILITY && !rx_page_valid_in && link100_in
      && s.link10 |=> s.pdf)
    else $error("parallel detect fault not flagged");
  a_restart_break: assert property (s.loaded && reg_wr_in && reg_addr_in == REG_BASIC_CONTROL
      && reg_wdata_in[BC_RESTART] && reg_wdata_in[BC_NEGOTIATE_STRAP_ENABLE] && !reg_wdata_in[BC_RESET]
      && s.st == ST_COMPLETE |=> s.st == ST_BREAK ##1 tx_halt_out)
    else $error("restart did not break link");
  a_loss_renego: assert property (s.loaded && s.st == ST_COMPLETE && s.link_up && !link_cur && !reg_wr_in
      |=> s.st == ST_BREAK)
    else $error("link loss did not renegotiate");
  a_break_silent: assert property (s.st == ST_BREAK |-> tx_halt_out && !flp_send_out)
    else $error("pulses sent during break");
  a_force_cross: assert property ($past(s.force_x) |-> crossover_out)
    else $error("forced crossover not applied");
  a_nlp_seven: assert property (s.loaded && s.nlp_cnt == NLP_GOOD && link_pulse_in && !loss_done
      |=> s.link10)
    else $error("seventh link pulse did not give link");
  a_direct_read: assert property (reg_rd_in && reg_addr_in == REG_IND_DIRECT
      |=> reg_rvalid_out && reg_rdata_out[5:0] == $past(s.indicator_direct_control))
    else $error("direct control read wrong");
endmodule
`default_nettype wire

// ==== test/ang_far_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module ang_far_partner (
  // Clock
  input wire logic clk_in,
  // Commands
  input wire logic send_page_in,
  input wire logic [15:0] page_in,
  input wire logic link100_on_in,
  input wire logic pulses10_on_in,
  // Line side
  output logic link100_out,
  output logic link_pulse_out,
  output logic [15:0] rx_page_out,
  output logic rx_page_valid_out
);
  logic [1:0] pace = 2'h0;
  initial begin
    link100_out = 1'b0;
    link_pulse_out = 1'b0;
    rx_page_out = 16'h0000;
    rx_page_valid_out = 1'b0;
  end
  always @(posedge clk_in) begin
    pace <= pace + 2'h1;
    link100_out <= link100_on_in;
    link_pulse_out <= pulses10_on_in && (pace == 2'h0);
    rx_page_valid_out <= send_page_in;
    // A code word is not held after its valid cycle, so stale data cannot pass for a page.
    rx_page_out <= send_page_in ? page_in : ~rx_page_out;
  end
endmodule
`default_nettype wire

// ==== test/tb_autoneg_mdix_led_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_mdix_led_control;
  import ang_pkg::*;
  localparam int BRK = 50;
  integer seed = 25794;
  int checks = 0;
  int n_mismatch = 0;
  int cyc = 0;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic s_hi = 1'b0, s_lo = 1'b0, s_xo = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, page = 16'h0000, reg_rdata, flp_word;
  logic reg_wr = 1'b0, reg_rd = 1'b0, send_page = 1'b0, on100 = 1'b0, on10 = 1'b0;
  logic act_tx = 1'b0, act_rx = 1'b0, col = 1'b0;
  logic reg_rvalid, link100, lpulse, pvalid, flp_send, tx_halt, xo, link_up, s100, fd, li, si, ai;
  logic [15:0] rx_page;
  always #12.5 ref_clk_in = ~ref_clk_in;
  ang_far_partner i_far (.clk_in(ref_clk_in), .send_page_in(send_page), .page_in(page),
    .link100_on_in(on100), .pulses10_on_in(on10), .link100_out(link100), .link_pulse_out(lpulse),
    .rx_page_out(rx_page), .rx_page_valid_out(pvalid));
  ang_link_ctrl #(.BREAK_CYCLES(BRK), .BLINK_CYCLES(4), .LOSS_CYCLES(40)) i_dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .negotiate_strap_enable_in(1'b1),
    .ability_strap_high_in(s_hi), .ability_strap_low_in(s_lo), .indicator_mode_select_in(1'b1),
    .crossover_strap_enable_in(s_xo), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
    .link100_in(link100), .link_pulse_in(lpulse), .packet10_valid_in(1'b0), .rx_page_in(rx_page),
    .rx_page_valid_in(pvalid), .tx_activity_in(act_tx), .rx_activity_in(act_rx), .collision_in(col),
    .flp_send_out(flp_send), .flp_word_out(flp_word), .tx_halt_out(tx_halt), .crossover_out(xo),
    .link_up_out(link_up), .speed100_out(s100), .full_duplex_out(fd), .link_indicator_out(li),
    .speed_indicator_out(si), .activity_collision_indicator_out(ai));
  function automatic logic [15:0] exp_adv(input logic hi, input logic lo);
    logic [3:0] a;
    a = lo ? (hi ? ADV_ALL : ADV_100_BOTH) : (hi ? ADV_HALF_BOTH : ADV_10_BOTH);
    return {7'h00, a, SELECTOR};
  endfunction
  function automatic logic [1:0] best(input logic [3:0] c);
    if (c[3]) return 2'b11;
    if (c[2]) return 2'b10;
    if (c[1]) return 2'b01;
    return 2'b00;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk_in) #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk_in) #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk_in) #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk_in) #1 reg_rd = 1'b0;
    chk("read valid", {15'h0, reg_rvalid}, 16'h0001);
    d = reg_rdata;
  endtask
  task automatic wait_hi(input string what, input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge ref_clk_in) #1;
      if ((sel == 0 ? flp_send : (sel == 1 ? link_up : tx_halt)) === 1'b1) break;
    end
    chk(what, {15'h0, i < lim}, 16'h0001);
  endtask
  task automatic restart();
    wr(REG_BASIC_CONTROL, 16'h1200);
    repeat (3) @(posedge ref_clk_in) #1;
    chk("halt", {15'h0, tx_halt}, 16'h0001);
    repeat (BRK / 2) @(posedge ref_clk_in) #1;
    chk("quiet", {15'h0, flp_send | ~tx_halt}, 16'h0000);
    wait_hi("bursts", 0, BRK + 30);
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    logic [15:0] d;
    logic [3:0] adv, pa;
    logic [1:0] b;
    logic [2:0] v;
    s_hi = 1'($random(seed));
    s_lo = 1'($random(seed));
    s_xo = 1'($random(seed));
    repeat (3) @(posedge ref_clk_in);
    #1 reset_n_in = 1'b1;
    repeat (5) @(posedge ref_clk_in);
    rd(REG_ABILITY_ADV, d);
    chk("strap adv", d, exp_adv(s_hi, s_lo));
    rd(REG_BASIC_STATUS, d);
    chk("fixed status", d & STATUS_FIXED, STATUS_FIXED);
    rd(5'h1F, d);
    chk("unmapped", d, 16'h0000);
    rd(REG_XCVR_CONTROL, d);
    chk("xcvr reset", d, {s_xo, 9'h000, 1'b1, 5'h00});
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      adv = (k == 0) ? ADV_ALL : 4'($random(seed));
      if (adv == 4'h0) adv = 4'h1;
      pa = 4'($random(seed));
      if ((pa & adv) == 4'h0) pa = adv;
      b = best(adv & pa);
      wr(REG_ABILITY_ADV, {7'h00, adv, SELECTOR});
      restart();
      chk("flp word", flp_word, {7'h00, adv, SELECTOR});
      page = {7'h00, pa, SELECTOR};
      on100 = b[1];
      on10 = ~b[1];
      send_page = 1'b1;
      @(posedge ref_clk_in) #1 send_page = 1'b0;
      repeat (4) @(posedge ref_clk_in) #1;
      chk("speed", {15'h0, s100}, {15'h0, b[1]});
      chk("duplex", {15'h0, fd}, {15'h0, b[0]});
      rd(REG_PARTNER_ABILITY, d);
      chk("partner word", d, page);
      wait_hi("link", 1, 80);
      rd(REG_STATUS_SUMMARY, d);
      chk("summary", d[2:1], {b[0], ~b[1]});
      on100 = 1'b0;
      on10 = 1'b0;
      wait_hi("relink", 2, 100);
    end
    $display("test negotiate done");
    restart();
    on100 = 1'b1;
    wait_hi("pd link", 1, 100);
    chk("pd mode", {14'h0, s100, fd}, 16'h0002);
    rd(REG_PARTNER_ABILITY, d);
    chk("pd100 word", d, PD_WORD_100);
    rd(REG_NEG_EXPANSION, d);
    chk("partner able", {15'h0, d[0]}, 16'h0000);
    rd(REG_BASIC_STATUS, d);
    chk("complete", {15'h0, d[5]}, 16'h0001);
    on100 = 1'b0;
    on10 = 1'b1;
    restart();
    wait_hi("pd10 link", 1, 120);
    rd(REG_PARTNER_ABILITY, d);
    chk("pd10 word", d, PD_WORD_10);
    on100 = 1'b1;
    restart();
    repeat (60) @(posedge ref_clk_in) #1;
    rd(REG_NEG_EXPANSION, d);
    chk("pd fault", {15'h0, d[4]}, 16'h0001);
    on100 = 1'b0;
    on10 = 1'b0;
    $display("test parallel done");
    wr(REG_BASIC_CONTROL, 16'h2000);
    repeat (3) @(posedge ref_clk_in) #1;
    chk("forced", {14'h0, s100, fd}, 16'h0002);
    wr(REG_BASIC_CONTROL, 16'h0100);
    repeat (3) @(posedge ref_clk_in) #1;
    chk("forced", {14'h0, s100, fd}, 16'h0001);
    wr(REG_XCVR_CONTROL, 16'h4020);
    repeat (3) @(posedge ref_clk_in) #1;
    chk("force swap", {15'h0, xo}, 16'h0001);
    wr(REG_XCVR_CONTROL, 16'h8020);
    repeat (3) @(posedge ref_clk_in) #1;
    chk("no auto", {15'h0, xo}, 16'h0000);
    act_tx = 1'($random(seed));
    act_rx = 1'($random(seed));
    repeat (3) @(posedge ref_clk_in) #1;
    chk("act led", {15'h0, ai}, {15'h0, (act_tx | act_rx) ^ s_lo});
    wr(REG_XCVR_CONTROL, 16'h8000);
    col = 1'b1;
    repeat (3) @(posedge ref_clk_in) #1;
    chk("col led", {15'h0, ai}, {15'h0, ~s_lo});
    v = 3'($random(seed));
    wr(REG_IND_DIRECT, {10'h000, 3'h7, v});
    rd(REG_IND_DIRECT, d);
    chk("direct read", d, {10'h000, 3'h7, v});
    chk("indicators", {13'h0, li, si, ai}, {13'h0, v ^ {1'b1, s_hi, s_lo}});
    $display("test forced done");
    wr(REG_BASIC_CONTROL, 16'h1000);
    wait_hi("leave forced", 0, BRK + 40);
    give_verdict();
  end
endmodule
`default_nettype wire
